// >>> design/hvi_link.v
// hvi_link.v: two-wire serial frame engine toward the high-voltage die.
// assumes the far die samples data on the rising link clock and answers
// on the data wire once this end releases it after the sixteenth bit.
`timescale 1ns/1ns
`include "hvi_map.vh"

module hvi_link (
	input  wire        i_clk,
	input  wire        i_rstn,
	input  wire        i_start,
	input  wire [15:0] i_tx_word,
	input  wire        i_dat_i,
	output reg         o_done,
	output reg  [8:0]  o_rx_word,
	output reg         o_link_clk,
	output reg         o_dat_o,
	output reg         o_dat_oe
);

localparam [1:0] ST_IDLE  = 2'b01;
localparam [1:0] ST_SHIFT = 2'b10;
// integer forms first, then cut to the counter widths on purpose
localparam integer HALF_LAST_I = `HVI_LINK_HALF_CYC - 1;
localparam integer TX_LAST_I   = `HVI_TX_BITS - 1;
localparam integer BIT_LAST_I  = `HVI_FRAME_BITS - 1;
localparam [2:0]   HALF_LAST   = HALF_LAST_I[2:0];
localparam [4:0]   TX_LAST     = TX_LAST_I[4:0];
localparam [4:0]   BIT_LAST    = BIT_LAST_I[4:0];

reg [1:0]  state_q;
reg [2:0]  div_q;
reg [4:0]  bit_q;
reg [15:0] sh_q;

////////////////////////////////////////////////////////////////////////////////
// frame sequencer: msb first, data changes while the link clock is low
always @(posedge i_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		state_q    <= ST_IDLE;
		div_q      <= 3'h0;
		bit_q      <= 5'h00;
		sh_q       <= 16'h0000;
		o_done     <= 1'b0;
		o_rx_word  <= 9'h000;
		o_link_clk <= 1'b0;
		o_dat_o    <= 1'b0;
		o_dat_oe   <= 1'b0;
	end else begin
		o_done <= 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (i_start) begin
					state_q    <= ST_SHIFT;
					div_q      <= 3'h0;
					bit_q      <= 5'h00;
					sh_q       <= i_tx_word;
					o_rx_word  <= 9'h000;
					o_dat_o    <= i_tx_word[15];
					o_dat_oe   <= 1'b1;
				end
			end
			ST_SHIFT: begin
				if (div_q == HALF_LAST) begin
					div_q      <= 3'h0;
					o_link_clk <= ~o_link_clk;
					if (!o_link_clk) begin
						// answer bits are taken on the rising edge
						if (bit_q > TX_LAST)
							o_rx_word <= {o_rx_word[7:0], i_dat_i};
					end else if (bit_q == BIT_LAST) begin
						state_q  <= ST_IDLE;
						o_done   <= 1'b1;
						o_dat_oe <= 1'b0;
						o_dat_o  <= 1'b0;
					end else begin
						bit_q    <= bit_q + 5'h01;
						sh_q     <= {sh_q[14:0], 1'b0};
						o_dat_o  <= sh_q[14];
						// wire released after the last sent bit, far end drives
						o_dat_oe <= (bit_q < TX_LAST);
					end
				end else begin
					div_q <= div_q + 3'h1;
				end
			end
			default: begin
				state_q    <= ST_IDLE;
				o_link_clk <= 1'b0;
				o_dat_oe   <= 1'b0;
			end
		endcase
	end
end

endmodule // hvi_link

// >>> design/hvi_map.vh
// hvi_map.vh: offsets, field positions, reset values and timing counts
// of the high-voltage indirect register interface.
// assumes a 20 MHz system clock and a 32-bit byte address on the register port.
`ifndef HVI_MAP_VH
`define HVI_MAP_VH

// memory-mapped offsets
`define HVI_CMD_ADDR      32'hFFFF0804
`define HVI_DAT_ADDR      32'hFFFF080C

// command codes
`define HVI_CMD_RD_CFG0   8'h00
`define HVI_CMD_RD_CFG1   8'h01
`define HVI_CMD_RD_STA    8'h02
`define HVI_CMD_RD_MON    8'h03
`define HVI_CMD_WR_CFG0   8'h08
`define HVI_CMD_WR_CFG1   8'h09

// command register read fields
`define HVI_CMD_BUSY_BIT  0
`define HVI_CMD_RDOK_BIT  1
`define HVI_CMD_TXOK_BIT  2

// data holding register fields
`define HVI_DAT_CMD_MSB   11
`define HVI_DAT_CMD_LSB   8
`define HVI_DAT_RST       12'h000

// config zero fields and reset
`define HVI_CFG_RST       8'h00
`define HVI_CFG0_TSD_DIS  7
`define HVI_CFG0_POSC_EN  6
`define HVI_CFG0_BSD      5
`define HVI_CFG0_WAKE     4
`define HVI_CFG0_PSM_EN   3
`define HVI_CFG0_LVF_EN   2
`define HVI_CFG0_LIN_MSB  1
`define HVI_CFG0_LIN_LSB  0
`define HVI_LIN_ENABLED   2'h2

// timing: system clock, link clock and worst-case command latency
`define HVI_SYS_CLK_KHZ   20000
`define HVI_LINK_CLK_KHZ  2560
`define HVI_LINK_HALF_CYC ((`HVI_SYS_CLK_KHZ + 2 * `HVI_LINK_CLK_KHZ - 1) / (2 * `HVI_LINK_CLK_KHZ))
`define HVI_CMD_LAT_NS    10000
`define HVI_CMD_LAT_CYC   ((`HVI_CMD_LAT_NS * (`HVI_SYS_CLK_KHZ / 1000)) / 1000)

// frame: 16 bits out (command, data), 9 bits back (data, acknowledge)
`define HVI_TX_BITS       16
`define HVI_FRAME_BITS    25

`endif

// >>> design/hvi_top.v
// hvi_top.v: command interpreter, data holding register and config zero of
// the high-voltage indirect register interface.
// assumes single-cycle register writes and reads on a 32-bit byte address,
// read data returned one clock later; link pins go to the high-voltage die.
`timescale 1ns/1ns
`include "hvi_map.vh"

module hvi_top (
	input  wire        I_CLK,
	input  wire        I_RSTN,
	input  wire [31:0] I_ADDR,
	input  wire        I_WR,
	input  wire        I_RD,
	input  wire [31:0] I_WDATA,
	input  wire        I_THERMAL_EVENT,
	input  wire        I_SUPPLY_LOW,
	input  wire        I_IRQ_ENABLE_SUPPLY,
	input  wire        I_LINK_DAT_I,
	output reg  [31:0] O_RDATA,
	output reg         O_WAKE_DRV_EN,
	output reg         O_WAKE_PIN_HIGH,
	output reg         O_WAKE_PIN_PULLDOWN,
	output reg         O_POSC_EN,
	output reg         O_BUS_PULLUP_EN,
	output reg         O_BIT_SERIAL_DEVICE_MODE,
	output reg         O_SUPPLY_MONITOR_EN,
	output reg         O_SUPPLY_IRQ_LINE,
	output reg         O_LOW_VOLTAGE_FLAG_EN,
	output reg         O_LIN_DRV_EN,
	output wire        O_LINK_CLK,
	output wire        O_LINK_DAT_O,
	output wire        O_LINK_DAT_OE
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_RUN  = 2'b10;

// true for the six documented command codes
function is_valid_cmd;
	input [7:0] cmd;
	begin
		is_valid_cmd = (cmd == `HVI_CMD_RD_CFG0) || (cmd == `HVI_CMD_RD_CFG1) ||
		               (cmd == `HVI_CMD_RD_STA)  || (cmd == `HVI_CMD_RD_MON)  ||
		               (cmd == `HVI_CMD_WR_CFG0) || (cmd == `HVI_CMD_WR_CFG1);
	end
endfunction

// write commands have bit 3 set, reads do not
function is_write_cmd;
	input [7:0] cmd;
	begin
		is_write_cmd = cmd[3];
	end
endfunction

reg  [1:0]  state_q;
reg  [7:0]  cmd_q;
reg  [11:0] hv_data_holding_q;
reg  [7:0]  hv_config_zero_q;
reg  [7:0]  hv_config_one_q;
reg         busy_q;
reg         tx_ok_q;
reg         rd_ok_q;
reg         start_q;
reg  [7:0]  hv_command_rd;
wire        link_done;
wire [8:0]  link_rx;
wire        cmd_sel;
wire        dat_sel;
wire        cmd_wr_ok;
wire        ack;

assign cmd_sel = (I_ADDR == `HVI_CMD_ADDR);
assign dat_sel = (I_ADDR == `HVI_DAT_ADDR);
// a new command is accepted only when idle and the code is documented
assign cmd_wr_ok = I_WR && cmd_sel && (state_q == ST_IDLE) &&
                   is_valid_cmd(I_WDATA[7:0]);
assign ack = link_rx[0];

////////////////////////////////////////////////////////////////////////////////
// serial link toward the high-voltage die
hvi_link u_link (
	.i_clk      (I_CLK),
	.i_rstn     (I_RSTN),
	.i_start    (start_q),
	.i_tx_word  ({cmd_q, hv_data_holding_q[7:0]}),
	.i_dat_i    (I_LINK_DAT_I),
	.o_done     (link_done),
	.o_rx_word  (link_rx),
	.o_link_clk (O_LINK_CLK),
	.o_dat_o    (O_LINK_DAT_O),
	.o_dat_oe   (O_LINK_DAT_OE)
);

////////////////////////////////////////////////////////////////////////////////
// command sequencer: busy from accept until the link frame ends
always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		state_q <= ST_IDLE;
		cmd_q   <= 8'h00;
		busy_q  <= 1'b0;
		tx_ok_q <= 1'b0;
		rd_ok_q <= 1'b0;
		start_q <= 1'b0;
	end else begin
		start_q <= 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (cmd_wr_ok) begin
					state_q <= ST_RUN;
					cmd_q   <= I_WDATA[7:0];
					busy_q  <= 1'b1;
					start_q <= 1'b1;
				end
			end
			ST_RUN: begin
				if (link_done) begin
					state_q <= ST_IDLE;
					busy_q  <= 1'b0;
					// outcome valid only once busy drops
					tx_ok_q <= ack;
					rd_ok_q <= ack && !is_write_cmd(cmd_q);
				end
			end
			default: begin
				state_q <= ST_IDLE;
				busy_q  <= 1'b0;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// data holding register: software owns the low byte, the command nibble is
// hardware only; a finished frame wins over a same-cycle software write
always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		hv_data_holding_q <= `HVI_DAT_RST;
	end else if ((state_q == ST_RUN) && link_done) begin
		hv_data_holding_q[`HVI_DAT_CMD_MSB:`HVI_DAT_CMD_LSB] <= cmd_q[3:0];
		if (ack && !is_write_cmd(cmd_q))
			hv_data_holding_q[7:0] <= link_rx[8:1];
	end else if (I_WR && dat_sel) begin
		hv_data_holding_q[7:0] <= I_WDATA[7:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// indirect config registers: updated only by an acknowledged write command
always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		hv_config_zero_q <= `HVI_CFG_RST;
		hv_config_one_q  <= `HVI_CFG_RST;
	end else if ((state_q == ST_RUN) && link_done && ack) begin
		if (cmd_q == `HVI_CMD_WR_CFG0)
			hv_config_zero_q <= hv_data_holding_q[7:0];
		if (cmd_q == `HVI_CMD_WR_CFG1)
			hv_config_one_q <= hv_data_holding_q[7:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// command register read view: reserved bits read zero
always @* begin
	hv_command_rd = 8'h00;
	hv_command_rd[`HVI_CMD_BUSY_BIT] = busy_q;
	hv_command_rd[`HVI_CMD_RDOK_BIT] = rd_ok_q;
	hv_command_rd[`HVI_CMD_TXOK_BIT] = tx_ok_q;
end

// registered read port; unmapped addresses read zero
always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		O_RDATA <= 32'h00000000;
	end else if (I_RD && cmd_sel) begin
		O_RDATA <= {24'h000000, hv_command_rd};
	end else if (I_RD && dat_sel) begin
		O_RDATA <= {20'h00000, hv_data_holding_q};
	end else begin
		O_RDATA <= 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// config zero controls, registered so each output leaves a flip-flop
always @(posedge I_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		O_WAKE_DRV_EN            <= 1'b1;
		O_WAKE_PIN_HIGH          <= 1'b0;
		O_WAKE_PIN_PULLDOWN      <= 1'b1;
		O_POSC_EN                <= 1'b0;
		O_BUS_PULLUP_EN          <= 1'b1;
		O_BIT_SERIAL_DEVICE_MODE <= 1'b0;
		O_SUPPLY_MONITOR_EN      <= 1'b0;
		O_SUPPLY_IRQ_LINE        <= 1'b0;
		O_LOW_VOLTAGE_FLAG_EN    <= 1'b0;
		O_LIN_DRV_EN             <= 1'b0;
	end else begin
		// thermal event kills the wake driver unless shutdown is disabled
		O_WAKE_DRV_EN <= hv_config_zero_q[`HVI_CFG0_TSD_DIS] ||
		                 !I_THERMAL_EVENT;
		O_WAKE_PIN_HIGH     <= hv_config_zero_q[`HVI_CFG0_WAKE];
		O_WAKE_PIN_PULLDOWN <= !hv_config_zero_q[`HVI_CFG0_WAKE];
		// start-up of the oscillator itself is analog, not timed here
		O_POSC_EN <= hv_config_zero_q[`HVI_CFG0_POSC_EN];
		O_BUS_PULLUP_EN          <= !hv_config_zero_q[`HVI_CFG0_BSD];
		O_BIT_SERIAL_DEVICE_MODE <= hv_config_zero_q[`HVI_CFG0_BSD];
		O_SUPPLY_MONITOR_EN <= hv_config_zero_q[`HVI_CFG0_PSM_EN];
		// level interrupt while the low-supply condition lasts
		O_SUPPLY_IRQ_LINE <= hv_config_zero_q[`HVI_CFG0_PSM_EN] &&
		                     I_IRQ_ENABLE_SUPPLY && I_SUPPLY_LOW;
		O_LOW_VOLTAGE_FLAG_EN <= hv_config_zero_q[`HVI_CFG0_LVF_EN];
		// reserved modes leave the driver off rather than guess
		O_LIN_DRV_EN <= (hv_config_zero_q[`HVI_CFG0_LIN_MSB:`HVI_CFG0_LIN_LSB] ==
		                 `HVI_LIN_ENABLED);
	end
end

endmodule // hvi_top

// >>> tb/hvi_far_die.sv
// far-die model: config zero/one, status and monitor behind the link.
// assumes sixteen bits in on rising link clock, then nine answer bits out.
`timescale 1ns/1ns
module hvi_far_die #(
	parameter [7:0] STA_VAL = 8'hA5,
	parameter [7:0] MON_VAL = 8'h08
) (
	input  wire i_clk,
	input  wire i_rstn,
	input  wire i_lclk,
	input  wire i_dat,
	input  wire i_nack,
	output wire o_dat
);
	reg  [14:0] sh_q;
	// start known: reset at time zero may give no edge to this model
	reg  [4:0]  cnt_q = 5'h00;
	reg  [7:0]  cfg0_q = 8'h00;
	reg  [7:0]  cfg1_q = 8'h00;
	reg  [8:0]  resp_q;
	reg         on_q = 1'b0;
	reg         bit_q;
	reg         junk_q;
	wire [15:0] word = {sh_q, i_dat};
	////////////////////////////////////////////////////////////////
	// receive and decode at the sixteenth rising edge
	always @(posedge i_lclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q  <= 5'h00;
			cfg0_q <= 8'h00;
			cfg1_q <= 8'h00;
		end else begin
			cnt_q <= (cnt_q == 5'h18) ? 5'h00 : cnt_q + 5'h01;
			sh_q  <= word[14:0];
			if (cnt_q == 5'h0F) begin
				resp_q <= {8'h00, !i_nack};
				case (word[15:8])
				8'h00: resp_q[8:1] <= cfg0_q;
				8'h01: resp_q[8:1] <= cfg1_q;
				8'h02: resp_q[8:1] <= STA_VAL;
				8'h03: resp_q[8:1] <= MON_VAL;
				8'h08: if (!i_nack) cfg0_q <= word[7:0];
				8'h09: if (!i_nack) cfg1_q <= word[7:0];
				default: resp_q <= 9'h000;
				endcase
			end
		end
	end
	// answer bits move on the falling edge so they hold over the sample
	always @(negedge i_lclk or negedge i_rstn) begin
		if (!i_rstn) begin
			on_q <= 1'b0;
		end else begin
			on_q  <= (cnt_q >= 5'h10);
			bit_q <= resp_q[5'h18 - cnt_q];
		end
	end
	// released line toggles, so a stale level never reads as an answer
	always @(posedge i_clk) junk_q <= (junk_q === 1'b1) ? 1'b0 : 1'b1;
	assign o_dat = on_q ? bit_q : junk_q;
endmodule // hvi_far_die

// >>> tb/hvi_top_properties.sv
// checker for hvi_top: link timing, config pins and read data shape.
// assumes only the top ports; bound to every hvi_top instance.
`timescale 1ns/1ns
`include "hvi_map.vh"
module hvi_top_properties (
	input wire        I_CLK,
	input wire        I_RSTN,
	input wire [31:0] I_ADDR,
	input wire        I_RD,
	input wire        I_THERMAL_EVENT,
	input wire        I_SUPPLY_LOW,
	input wire        I_IRQ_ENABLE_SUPPLY,
	input wire [31:0] O_RDATA,
	input wire        O_WAKE_DRV_EN,
	input wire        O_WAKE_PIN_HIGH,
	input wire        O_WAKE_PIN_PULLDOWN,
	input wire        O_BUS_PULLUP_EN,
	input wire        O_BIT_SERIAL_DEVICE_MODE,
	input wire        O_SUPPLY_MONITOR_EN,
	input wire        O_SUPPLY_IRQ_LINE,
	input wire        O_LINK_CLK,
	input wire        O_LINK_DAT_O,
	input wire        O_LINK_DAT_OE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	reg [7:0] oe_cnt_q;
	// length of the driven part of a frame
	always @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) oe_cnt_q <= 8'h00;
		else oe_cnt_q <= O_LINK_DAT_OE ? oe_cnt_q + 8'h01 : 8'h00;
	end
	sequence hi_phase;
		O_LINK_CLK [*4] ##1 !O_LINK_CLK;
	endsequence
	clk_phase_a: assert property ($rose(O_LINK_CLK) |-> hi_phase)
		else $error("link clock high phase wrong");
	frame_len_a: assert property ($fell(O_LINK_DAT_OE) |-> oe_cnt_q inside {[126:130]})
		else $error("driven frame length wrong");
	dat_hold_a: assert property (O_LINK_DAT_OE && O_LINK_CLK && $past(O_LINK_CLK)
		|-> $stable(O_LINK_DAT_O)) else $error("link data moved in high phase");
	wake_pair_a: assert property (O_WAKE_PIN_PULLDOWN != O_WAKE_PIN_HIGH)
		else $error("wake drive and pull-down agree");
	pullup_pair_a: assert property (O_BUS_PULLUP_EN != O_BIT_SERIAL_DEVICE_MODE)
		else $error("pull-up and serial mode agree");
	thermal_shut_a: assert property (!$past(I_THERMAL_EVENT) |-> O_WAKE_DRV_EN)
		else $error("wake driver off without thermal event");
	supply_irq_a: assert property (O_SUPPLY_IRQ_LINE == (O_SUPPLY_MONITOR_EN
		&& $past(I_SUPPLY_LOW) && $past(I_IRQ_ENABLE_SUPPLY))) else $error("supply irq wrong");
	cmd_read_a: assert property ($past(I_RD && I_ADDR == `HVI_CMD_ADDR)
		|-> O_RDATA[31:3] == 29'h0) else $error("command read upper bits set");
	dat_read_a: assert property ($past(I_RD && I_ADDR == `HVI_DAT_ADDR)
		|-> O_RDATA[31:12] == 20'h0) else $error("data read wider than 12 bits");
	rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("read data outside read cycle");
endmodule // hvi_top_properties
bind hvi_top hvi_top_properties u_hvi_top_properties (
	.I_CLK                    (I_CLK),
	.I_RSTN                   (I_RSTN),
	.I_ADDR                   (I_ADDR),
	.I_RD                     (I_RD),
	.I_THERMAL_EVENT          (I_THERMAL_EVENT),
	.I_SUPPLY_LOW             (I_SUPPLY_LOW),
	.I_IRQ_ENABLE_SUPPLY      (I_IRQ_ENABLE_SUPPLY),
	.O_RDATA                  (O_RDATA),
	.O_WAKE_DRV_EN            (O_WAKE_DRV_EN),
	.O_WAKE_PIN_HIGH          (O_WAKE_PIN_HIGH),
	.O_WAKE_PIN_PULLDOWN      (O_WAKE_PIN_PULLDOWN),
	.O_BUS_PULLUP_EN          (O_BUS_PULLUP_EN),
	.O_BIT_SERIAL_DEVICE_MODE (O_BIT_SERIAL_DEVICE_MODE),
	.O_SUPPLY_MONITOR_EN      (O_SUPPLY_MONITOR_EN),
	.O_SUPPLY_IRQ_LINE        (O_SUPPLY_IRQ_LINE),
	.O_LINK_CLK               (O_LINK_CLK),
	.O_LINK_DAT_O             (O_LINK_DAT_O),
	.O_LINK_DAT_OE            (O_LINK_DAT_OE)
);

// >>> tb/test_hvi_top.sv
// bench for hvi_top with the far-die model on the link.
// assumes the model answers every frame; nack forces failures.
`timescale 1ns/1ns
`include "hvi_map.vh"
module test_hvi_top;
	localparam [7:0] STA = 8'hA5;
	localparam [7:0] MON = 8'h08;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg  [31:0] addr = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg  [31:0] wdata = 32'h0;
	reg         therm = 1'b0;
	reg         slow = 1'b0;
	reg         irq_enable_reg = 1'b0;
	reg         nack = 1'b0;
	reg         poll = 1'b0;
	reg         rd_l = 1'b0;
	reg         poll_l = 1'b0;
	reg  [7:0]  v;
	reg  [7:0]  c1;
	wire [31:0] rdata;
	wire [9:0]  pins;
	wire        lclk, ldo, loe, far_dat;
	wire        ldi = loe ? ldo : far_dat;
	reg  [31:0] expq[$];
	int         err_count = 0;
	int         n_checks = 0;
	int         i;
	always #25 clk = ~clk;
	hvi_top u_hvi_top (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
		.I_WDATA(wdata), .I_THERMAL_EVENT(therm), .I_SUPPLY_LOW(slow),
		.I_IRQ_ENABLE_SUPPLY(irq_enable_reg), .I_LINK_DAT_I(ldi), .O_RDATA(rdata),
		.O_WAKE_DRV_EN(pins[9]), .O_WAKE_PIN_HIGH(pins[8]), .O_WAKE_PIN_PULLDOWN(pins[7]),
		.O_POSC_EN(pins[6]), .O_BUS_PULLUP_EN(pins[5]), .O_BIT_SERIAL_DEVICE_MODE(pins[4]),
		.O_SUPPLY_MONITOR_EN(pins[3]), .O_SUPPLY_IRQ_LINE(pins[2]),
		.O_LOW_VOLTAGE_FLAG_EN(pins[1]), .O_LIN_DRV_EN(pins[0]), .O_LINK_CLK(lclk),
		.O_LINK_DAT_O(ldo), .O_LINK_DAT_OE(loe));
	hvi_far_die #(.STA_VAL(STA), .MON_VAL(MON)) u_hvi_far_die (.i_clk(clk), .i_rstn(rstn),
		.i_lclk(lclk), .i_dat(ldo), .i_nack(nack), .o_dat(far_dat));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
		expq.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// poll reads bypass the queue; first one must still see busy
	task automatic wait_idle;
		int k;
		poll <= 1'b1;
		for (k = 0; k < 300; k++) begin
			rd_reg(`HVI_CMD_ADDR, 32'h0);
			@(negedge clk);
			void'(expq.pop_back());
			if (k == 0) chk("busy", 32'h1, rdata & 32'h1);
			if (rdata[0] === 1'b0) break;
		end
		poll <= 1'b0;
		if (k == 300) chk("idle wait", 32'h0, 32'h1);
	endtask
	task automatic hv_cmd(input logic [7:0] c, input logic [7:0] d);
		// software keeps the read-only command nibble at zero
		wr_reg(`HVI_DAT_ADDR, {20'h0, 4'h0, d});
		wr_reg(`HVI_CMD_ADDR, {24'h0, c});
		wait_idle();
	endtask
	task automatic pins_chk(input logic [7:0] c);
		repeat (3) @(negedge clk);
		chk("pins", {22'h0, c[7] | !therm, c[4], !c[4], c[6], !c[5], c[5], c[3],
			c[3] & slow & irq_enable_reg, c[2], c[1:0] == 2'b10}, {22'h0, pins});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// read results come back one cycle after the strobe
	always @(negedge clk) begin
		if (rd_l && !poll_l) chk("rdata", expq.pop_front(), rdata);
		rd_l = rd;
		poll_l = poll;
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	initial begin
		i = $urandom(32'hCDF2);
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(`HVI_DAT_ADDR, 32'h0);
		rd_reg(`HVI_CMD_ADDR, 32'h0);
		rd_reg(32'hFFFF0808, 32'h0);
		pins_chk(8'h00);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			v = 8'($urandom);
			v[1:0] = i[1:0];
			@(posedge clk);
			{therm, slow, irq_enable_reg} <= 3'($urandom);
			hv_cmd(`HVI_CMD_WR_CFG0, v);
			rd_reg(`HVI_CMD_ADDR, 32'h4);
			rd_reg(`HVI_DAT_ADDR, {20'h0, 4'h8, v});
			pins_chk(v);
			hv_cmd(`HVI_CMD_RD_CFG0, 8'h00);
			rd_reg(`HVI_CMD_ADDR, 32'h6);
			rd_reg(`HVI_DAT_ADDR, {24'h0, v});
		end
		$display("test config zero done");
		c1 = 8'($urandom);
		hv_cmd(`HVI_CMD_WR_CFG1, c1);
		for (i = 1; i < 4; i++) begin
			hv_cmd(i[7:0], 8'h00);
			rd_reg(`HVI_DAT_ADDR, {20'h0, i[3:0], i == 1 ? c1 : i == 2 ? STA : MON});
		end
		$display("test readback codes done");
		nack <= 1'b1;
		hv_cmd(`HVI_CMD_WR_CFG0, ~v);
		rd_reg(`HVI_CMD_ADDR, 32'h0);
		pins_chk(v);
		nack <= 1'b0;
		wr_reg(`HVI_CMD_ADDR, 32'h0A);
		rd_reg(`HVI_CMD_ADDR, 32'h0);
		rd_reg(`HVI_DAT_ADDR, {20'h0, 4'h8, ~v});
		@(negedge clk);
		chk("link oe", 32'h0, {31'h0, loe});
		$display("test failure and reserved done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		pins_chk(8'h00);
		$display("test second reset done");
		give_verdict();
	end
endmodule // test_hvi_top
